// [hw/fast_gpio_pkg.sv]
package fast_gpio_pkg;
    // =========================================
    // Register window
    localparam logic [31:0] PORT_WINDOW_BASE = 32'h00C0_0000;
    localparam logic [31:0] WINDOW_MASK = 32'hFFFF_FFF0;
    localparam int PORT_WIDTH = 16;
    localparam logic [3:0] OFS_OUTPUT_SELECT = 4'h0;
    localparam logic [3:0] OFS_PORT_VALUE = 4'h2;
    localparam logic [3:0] OFS_PIN_CLAIM = 4'h4;
    localparam logic [3:0] OFS_BIT_ZERO_STROBE = 4'h6;
    localparam logic [3:0] OFS_OUTPUT_SELECT_ALIAS_A = 4'h8;
    localparam logic [3:0] OFS_BIT_ONE_STROBE = 4'hA;
    localparam logic [3:0] OFS_OUTPUT_SELECT_ALIAS_B = 4'hC;
    localparam logic [3:0] OFS_BIT_FLIP_STROBE = 4'hE;
    localparam logic [15:0] RESET_OUTPUT_SELECT = 16'h0000;
    localparam logic [15:0] RESET_PORT_VALUE = 16'h0000;
    localparam logic [15:0] RESET_PIN_CLAIM = 16'h0000;
    // =========================================
    // Access sizes
    typedef enum logic [1:0] {
        SIZE_BYTE,
        SIZE_HALF,
        SIZE_WORD
    } access_size_t;
    typedef enum logic [1:0] {
        OP_NONE,
        OP_CLEAR,
        OP_SET,
        OP_FLIP
    } strobe_op_t;
endpackage

// [hw/lane_decoder.sv]
module lane_decoder (
    input wire logic [1:0] addr_lo,
    input wire fast_gpio_pkg::access_size_t size,
    output logic [3:0] lane_en
);
    import fast_gpio_pkg::*;
    // =========================================
    // Byte lanes, big-endian: lane 3 is bits 31:24 at byte offset 0
    function automatic logic [3:0] lanes_of(input logic [1:0] a, input access_size_t s);
        logic [3:0] l;
        l = 4'h0;
        case (s)
            SIZE_BYTE: l = 4'h8 >> a;
            SIZE_HALF: l = a[1] ? 4'h3 : 4'hC;
            SIZE_WORD: l = 4'hF;
            default: l = 4'h0;
        endcase
        return l;
    endfunction
    assign lane_en = lanes_of(addr_lo, size);
endmodule

// [hw/value_merge.sv]
module value_merge (
    input wire logic [15:0] cur,
    input wire logic [15:0] wdata,
    input wire logic [1:0] lanes,
    input wire fast_gpio_pkg::strobe_op_t op,
    output logic [15:0] merged
);
    import fast_gpio_pkg::*;
    logic [15:0] mask;
    logic [15:0] applied;
    assign mask = {{8{lanes[1]}}, {8{lanes[0]}}};
    always_comb begin
        case (op)
            OP_CLEAR: applied = cur & wdata;
            OP_SET: applied = cur | wdata;
            OP_FLIP: applied = cur ^ wdata;
            default: applied = wdata;
        endcase
    end
    // Unwritten lanes keep their bits
    assign merged = (applied & mask) | (cur & ~mask);
endmodule

// [hw/fast_local_bus_gpio_port.sv]
module fast_local_bus_gpio_port #(
    parameter int WIDTH = fast_gpio_pkg::PORT_WIDTH
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic sys_rst,
    input wire logic bus_sel,
    input wire logic [31:0] bus_addr,
    input wire logic bus_write,
    input wire fast_gpio_pkg::access_size_t bus_size,
    input wire logic bus_supervisor,
    input wire logic [31:0] bus_wdata,
    output logic [31:0] bus_rdata,
    output logic bus_ready,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out,
    output logic [WIDTH-1:0] pin_oe,
    output logic [WIDTH-1:0] pin_claim
);
    import fast_gpio_pkg::*;
    // =========================================
    // Address phase capture
    // Two-stage bus: address phase registered, data phase is the next cycle.
    logic dp_valid_r;
    logic dp_write_r;
    logic [3:0] dp_ofs_r;
    access_size_t dp_size_r;
    logic hit;
    // Privilege input deliberately unused by decode
    assign hit = bus_sel && ((bus_addr & WINDOW_MASK) == PORT_WINDOW_BASE);

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            dp_valid_r <= 1'b0;
            dp_write_r <= 1'b0;
            dp_ofs_r <= 4'h0;
            dp_size_r <= SIZE_BYTE;
        end else begin
            dp_valid_r <= hit;
            dp_write_r <= bus_write;
            dp_ofs_r <= bus_addr[3:0];
            dp_size_r <= bus_size;
        end
    end

    // Zero wait states: ready always high
    assign bus_ready = 1'b1;

    // =========================================
    // Lane and word decode
    logic [3:0] lane_en;
    lane_decoder u_lanes (
        .addr_lo(dp_ofs_r[1:0]),
        .size(dp_size_r),
        .lane_en(lane_en)
    );
    // Upper halfword (lanes 3:2) is the even register, lower the odd one
    logic [3:0] hi_ofs;
    logic [3:0] lo_ofs;
    logic hi_wr;
    logic lo_wr;
    assign hi_ofs = {dp_ofs_r[3:2], 2'b00};
    assign lo_ofs = {dp_ofs_r[3:2], 2'b10};
    assign hi_wr = dp_valid_r && dp_write_r && (lane_en[3:2] != 2'b00);
    assign lo_wr = dp_valid_r && dp_write_r && (lane_en[1:0] != 2'b00);

    function automatic strobe_op_t op_of(input logic [3:0] ofs);
        case (ofs)
            OFS_BIT_ZERO_STROBE: return OP_CLEAR;
            OFS_BIT_ONE_STROBE: return OP_SET;
            OFS_BIT_FLIP_STROBE: return OP_FLIP;
            default: return OP_NONE;
        endcase
    endfunction

    // =========================================
    // Register writes
    logic [15:0] output_select_r;
    logic [15:0] pin_claim_reg_r;
    logic [15:0] port_value_r;
    logic [15:0] wr_half;
    logic [1:0] wr_lanes;
    logic [3:0] wr_ofs;
    logic val_wr;
    strobe_op_t wr_op;
    logic [15:0] val_nxt;
    logic [15:0] dir_nxt;
    logic [15:0] claim_nxt;
    // Only one of the two halves names a value/strobe register per word
    assign wr_ofs = (hi_wr && op_of(hi_ofs) != OP_NONE) ? hi_ofs : lo_ofs;
    assign wr_half = (wr_ofs == hi_ofs) ? bus_wdata[31:16] : bus_wdata[15:0];
    assign wr_lanes = (wr_ofs == hi_ofs) ? lane_en[3:2] : lane_en[1:0];
    assign wr_op = op_of(wr_ofs);
    assign val_wr = ((wr_ofs == hi_ofs) ? hi_wr : lo_wr)
        && (wr_op != OP_NONE || wr_ofs == OFS_PORT_VALUE);

    value_merge u_val (
        .cur(port_value_r),
        .wdata(wr_half),
        .lanes(wr_lanes),
        .op(wr_op),
        .merged(val_nxt)
    );
    value_merge u_dir (
        .cur(output_select_r),
        .wdata(bus_wdata[31:16]),
        .lanes(lane_en[3:2]),
        .op(OP_NONE),
        .merged(dir_nxt)
    );
    value_merge u_claim (
        .cur(pin_claim_reg_r),
        .wdata(bus_wdata[31:16]),
        .lanes(lane_en[3:2]),
        .op(OP_NONE),
        .merged(claim_nxt)
    );

    // Offsets 0x8 and 0xC fall through: accepted, no state change
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            output_select_r <= RESET_OUTPUT_SELECT;
            pin_claim_reg_r <= RESET_PIN_CLAIM;
        end else begin
            if (hi_wr && hi_ofs == OFS_OUTPUT_SELECT) begin
                output_select_r <= dir_nxt;
            end
            if (hi_wr && hi_ofs == OFS_PIN_CLAIM) begin
                pin_claim_reg_r <= claim_nxt;
            end
        end
    end

    // Async clear so pins drop with system reset even with no clock
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            port_value_r <= RESET_PORT_VALUE;
        end else if (srst) begin
            port_value_r <= RESET_PORT_VALUE;
        end else if (val_wr) begin
            port_value_r <= val_nxt;
        end
    end

    // =========================================
    // Pin drive
    assign pin_claim = pin_claim_reg_r;
    assign pin_oe = pin_claim_reg_r & output_select_r;
    assign pin_out = port_value_r & pin_oe;

    // =========================================
    // Read data
    // Sampled at the data-phase edge; result presented the following cycle.
    // Registers come in as arguments so the continuous assignment tracks them
    function automatic logic [15:0] read_of(input logic [3:0] ofs, input logic [15:0] pv,
            input logic [15:0] dir, input logic [15:0] claim);
        case (ofs)
            OFS_OUTPUT_SELECT: return dir;
            OFS_OUTPUT_SELECT_ALIAS_A: return dir;
            OFS_OUTPUT_SELECT_ALIAS_B: return dir;
            OFS_PIN_CLAIM: return claim;
            default: return pv;
        endcase
    endfunction
    logic [15:0] pv_view;
    logic [31:0] rdata_nxt;
    // Input pins read live level; outputs read the register
    assign pv_view = (pin_in & ~output_select_r) | (port_value_r & output_select_r);
    assign rdata_nxt = {read_of(hi_ofs, pv_view, output_select_r, pin_claim_reg_r),
        read_of(lo_ofs, pv_view, output_select_r, pin_claim_reg_r)};

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            bus_rdata <= 32'h0000_0000;
        end else if (dp_valid_r && !dp_write_r) begin
            bus_rdata <= rdata_nxt;
        end
    end

    // =========================================
    // Checks
    // Data-phase conditions that several properties share
    sequence s_value_write;
        hi_wr || lo_wr;
    endsequence
    sequence s_read_phase;
        dp_valid_r && !dp_write_r;
    endsequence
    // Upper field only, at the two offsets whose upper field is inert
    sequence s_alias_write;
        s_value_write ##0 ((dp_ofs_r[3:2] == 2'b10 || dp_ofs_r[3:2] == 2'b11)
            && lane_en[3:2] != 2'b00 && lane_en[1:0] == 2'b00);
    endsequence
    sequence s_full_value_write;
        s_value_write ##0 (val_wr && wr_op == OP_NONE && wr_lanes == 2'b11);
    endsequence

    AST_READY_ALWAYS: assert property (@(posedge ref_clk) disable iff (srst)
        bus_ready)
        else $error("bus not ready");

    AST_RESET_CLEARS: assert property (@(posedge ref_clk)
        srst |=> output_select_r == 16'h0000 && pin_claim_reg_r == 16'h0000
            && port_value_r == 16'h0000)
        else $error("reset did not clear");

    AST_OE_GATED: assert property (@(posedge ref_clk) disable iff (srst)
        (pin_oe & ~pin_claim) == 16'h0000)
        else $error("unclaimed pin driven");

    AST_DIR_OE: assert property (@(posedge ref_clk) disable iff (srst)
        pin_oe == (pin_claim & output_select_r))
        else $error("direction mismatch");

    AST_SET_STROBE: assert property (@(posedge ref_clk)
        disable iff (srst || sys_rst)
        (val_wr && wr_op == OP_SET && wr_lanes == 2'b11) |=>
        (port_value_r & $past(wr_half)) == $past(wr_half))
        else $error("set strobe failed");

    AST_CLEAR_STROBE: assert property (@(posedge ref_clk)
        disable iff (srst || sys_rst)
        (val_wr && wr_op == OP_CLEAR && wr_lanes == 2'b11) |=>
        (port_value_r & ~$past(wr_half)) == 16'h0000)
        else $error("clear strobe failed");

    AST_FLIP_STROBE: assert property (@(posedge ref_clk)
        disable iff (srst || sys_rst)
        (val_wr && wr_op == OP_FLIP && wr_lanes == 2'b11) |=>
        port_value_r == ($past(port_value_r) ^ $past(wr_half)))
        else $error("flip strobe failed");

    AST_VALUE_WRITE: assert property (@(posedge ref_clk)
        disable iff (srst || sys_rst)
        s_full_value_write |=> port_value_r == $past(bus_wdata[15:0]))
        else $error("value write failed");

    // Async clear already shows at the first edge that samples it
    AST_SYS_RST_CLEARS: assert property (@(posedge ref_clk)
        sys_rst |-> port_value_r == 16'h0000)
        else $error("system reset did not clear value");

    AST_NARROW_VALUE: assert property (@(posedge ref_clk)
        disable iff (srst || sys_rst)
        (val_wr && wr_lanes == 2'b10) |=>
        port_value_r[7:0] == $past(port_value_r[7:0]))
        else $error("unwritten value lane changed");

    AST_NARROW_DIR: assert property (@(posedge ref_clk)
        disable iff (srst)
        (hi_wr && hi_ofs == OFS_OUTPUT_SELECT && lane_en[3:2] == 2'b10) |=>
        output_select_r[7:0] == $past(output_select_r[7:0]))
        else $error("unwritten direction lane changed");

    AST_ALIAS_WRITE_INERT: assert property (@(posedge ref_clk)
        disable iff (srst || sys_rst)
        s_alias_write |=> $stable(output_select_r) && $stable(pin_claim_reg_r)
            && $stable(port_value_r))
        else $error("alias write changed state");

    // No write in the data phase, so no register may move
    AST_IDLE_HOLDS: assert property (@(posedge ref_clk)
        disable iff (srst || sys_rst)
        !(dp_valid_r && dp_write_r) |=> $stable(output_select_r)
            && $stable(pin_claim_reg_r) && $stable(port_value_r))
        else $error("state changed with no write");

    // Lower field of every read word is the port value view
    AST_VALUE_READ: assert property (@(posedge ref_clk) disable iff (srst)
        s_read_phase |=> bus_rdata[15:0] ==
            (($past(pin_in) & ~$past(output_select_r))
            | ($past(port_value_r) & $past(output_select_r))))
        else $error("value read wrong");

    AST_DIR_READ: assert property (@(posedge ref_clk) disable iff (srst)
        (s_read_phase ##0 dp_ofs_r[3:2] == 2'b00) |=>
        bus_rdata[31:16] == $past(output_select_r))
        else $error("direction read wrong");

    AST_CLAIM_READ: assert property (@(posedge ref_clk) disable iff (srst)
        (s_read_phase ##0 dp_ofs_r[3:2] == 2'b01) |=>
        bus_rdata[31:16] == $past(pin_claim_reg_r))
        else $error("claim read wrong");

    AST_ALIAS_READ: assert property (@(posedge ref_clk) disable iff (srst)
        (s_read_phase ##0 (dp_ofs_r[3:2] == 2'b10 || dp_ofs_r[3:2] == 2'b11)) |=>
        bus_rdata[31:16] == $past(output_select_r))
        else $error("alias read wrong");

    // Read data stands until the next read
    AST_RDATA_HOLDS: assert property (@(posedge ref_clk) disable iff (srst)
        !(dp_valid_r && !dp_write_r) |=> $stable(bus_rdata))
        else $error("read data changed with no read");
endmodule

// [tb/local_bus_master.sv]
module local_bus_master import fast_gpio_pkg::*; (
    input wire logic ref_clk,
    output logic bus_sel,
    output logic [31:0] bus_addr,
    output logic bus_write,
    output fast_gpio_pkg::access_size_t bus_size,
    output logic bus_supervisor,
    output logic [31:0] bus_wdata,
    input wire logic [31:0] bus_rdata,
    input wire logic bus_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    // ========================================
    // Core side of the two-stage local bus
    initial begin
        bus_sel = 1'b0;
        bus_addr = 32'h0;
        bus_write = 1'b0;
        bus_size = SIZE_BYTE;
        bus_supervisor = 1'b0;
        bus_wdata = 32'h0;
    end
    // Gap models a slow core; released lines flip so stale data never looks valid
    task automatic xfer(input int gap, input logic w, input logic [31:0] a,
                        input access_size_t s, input logic [31:0] d, input logic sv,
                        output logic [31:0] r);
        repeat (gap + 1) @(posedge ref_clk);
        #1;
        bus_sel = 1'b1;
        bus_addr = a;
        bus_write = w;
        bus_size = s;
        bus_supervisor = sv;
        @(posedge ref_clk);
        #1;
        bus_sel = 1'b0;
        bus_addr = ~a;
        bus_wdata = w ? d : ~bus_wdata;
        @(posedge ref_clk);
        while (bus_ready !== 1'b1) @(posedge ref_clk);
        #1;
        r = bus_rdata;
        bus_wdata = ~bus_wdata;
    endtask
endmodule

// [tb/fast_local_bus_gpio_port_bench.sv]
module fast_local_bus_gpio_port_bench import fast_gpio_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, srst, sys_rst, sel, wr_en, sv, ready;
    logic [31:0] addr, wdata, rdata;
    access_size_t size;
    logic [15:0] pin_in, pin_out, pin_oe, pin_claim, dir_m, val_m, clm_m;
    int errors = 0;
    int n_compared = 0;
    local_bus_master mst_u (.ref_clk(ref_clk), .bus_sel(sel), .bus_addr(addr),
        .bus_write(wr_en), .bus_size(size), .bus_supervisor(sv), .bus_wdata(wdata),
        .bus_rdata(rdata), .bus_ready(ready));
    fast_local_bus_gpio_port #(.WIDTH(PORT_WIDTH)) dut_u (.ref_clk(ref_clk), .srst(srst),
        .sys_rst(sys_rst), .bus_sel(sel), .bus_addr(addr), .bus_write(wr_en),
        .bus_size(size), .bus_supervisor(sv), .bus_wdata(wdata), .bus_rdata(rdata),
        .bus_ready(ready), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_claim(pin_claim));
    // ========================================
    // Checks and expected register state
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        if (errors == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic mbyte(input logic [3:0] b, input logic [7:0] v);
        logic [15:0] m;
        m = b[0] ? 16'h00FF : 16'hFF00;
        case (b[3:1])
            3'h0: dir_m = (dir_m & ~m) | ({v, v} & m);
            3'h1: val_m = (val_m & ~m) | ({v, v} & m);
            3'h2: clm_m = (clm_m & ~m) | ({v, v} & m);
            3'h3: val_m = val_m & ({v, v} | ~m);
            3'h5: val_m = val_m | ({v, v} & m);
            3'h7: val_m = val_m ^ ({v, v} & m);
            default: ;
        endcase
    endtask
    // Narrow data is replicated on every lane, so lane placement cannot mislead
    task automatic wr(input logic [3:0] a, input access_size_t s, input logic [31:0] d);
        logic [31:0] w, r;
        w = (s == SIZE_BYTE) ? {4{d[7:0]}} : (s == SIZE_HALF) ? {2{d[15:0]}} : d;
        mst_u.xfer($urandom_range(2), 1'b1, PORT_WINDOW_BASE | 32'(a), s, w, 1'($urandom), r);
        for (int i = 0; i < (1 << s); i++) mbyte(4'(a + i), w[8 * (3 - ((a + i) % 4)) +: 8]);
    endtask
    task automatic pins;
        chk({16'h0, pin_oe}, {16'h0, clm_m & dir_m});
        chk({16'h0, pin_out}, {16'h0, val_m & clm_m & dir_m});
        chk({16'h0, pin_claim}, {16'h0, clm_m});
    endtask
    // Value bits of unclaimed pins are undefined, hence the claim mask
    task automatic rdchk(input logic [3:0] a);
        logic [31:0] r;
        logic [15:0] e, m;
        mst_u.xfer(0, 1'b0, PORT_WINDOW_BASE | 32'(a), SIZE_HALF, 32'h0, 1'($urandom), r);
        chk({31'h0, ready}, 32'h1);
        m = 16'hFFFF;
        case (a[3:1])
            3'h0, 3'h4, 3'h6: e = dir_m;
            3'h2: e = clm_m;
            default: begin
                e = (dir_m & val_m) | (~dir_m & pin_in);
                m = clm_m;
            end
        endcase
        chk({16'h0, (a[1] ? r[15:0] : r[31:16]) & m}, {16'h0, e & m});
    endtask
    task automatic hard_reset;
        srst = 1'b1;
        repeat (2) @(posedge ref_clk);
        #1;
        srst = 1'b0;
        dir_m = 16'h0;
        val_m = 16'h0;
        clm_m = 16'h0;
    endtask
    // ========================================
    // Stimulus
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        #100us;
        errors++;
        close_out();
    end
    initial begin
        logic [31:0] r;
        logic [3:0] a;
        access_size_t s;
        sys_rst = 1'b0;
        pin_in = 16'h0;
        void'($urandom(18210));
        hard_reset();
        for (int i = 0; i < 16; i += 2) rdchk(4'(i));
        wr(4'h4, SIZE_HALF, 32'hFFFF);
        wr(4'h0, SIZE_WORD, 32'hFFFF_A5A5);
        pins();
        wr(4'h6, SIZE_HALF, 32'h0FF0);
        rdchk(4'h6);
        wr(4'hA, SIZE_BYTE, 32'h81);
        rdchk(4'hA);
        wr(4'hE, SIZE_HALF, 32'h00FF);
        rdchk(4'hE);
        pins();
        wr(4'h8, SIZE_WORD, 32'h1234_0F00);
        wr(4'hC, SIZE_HALF, 32'h0000);
        rdchk(4'h8);
        rdchk(4'hC);
        mst_u.xfer(0, 1'b1, PORT_WINDOW_BASE + 32'h10, SIZE_WORD, 32'h0, 1'b1, r);
        pins();
        wr(4'h0, SIZE_HALF, 32'h00FF);
        pin_in = 16'($urandom);
        rdchk(4'h2);
        for (int i = 0; i < 200; i++) begin
            s = access_size_t'($urandom_range(2));
            a = 4'($urandom) & ~4'((1 << s) - 1);
            wr(a, s, $urandom);
            pin_in = 16'($urandom);
            pins();
            rdchk(4'($urandom) & 4'hE);
        end
        wr(4'h4, SIZE_WORD, 32'hFFFF_FFFF);
        wr(4'h0, SIZE_WORD, 32'hFFFF_FFFF);
        @(posedge ref_clk);
        #1;
        sys_rst = 1'b1;
        #2;
        val_m = 16'h0;
        chk({16'h0, pin_out}, 32'h0);
        @(posedge ref_clk);
        #1;
        sys_rst = 1'b0;
        rdchk(4'h2);
        hard_reset();
        pins();
        rdchk(4'h4);
        close_out();
    end
endmodule
